// ### rtl/scan_port_pkg.sv
// Shared constants and types for the boundary-scan test port
package scan_port_pkg;

  // Sixteen controller states, binary codes written out
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'h0,
    RUN_TEST_IDLE    = 4'h1,
    SELECT_DR        = 4'h2,
    CAPTURE_DR       = 4'h3,
    SHIFT_DR         = 4'h4,
    EXIT1_DR         = 4'h5,
    PAUSE_DR         = 4'h6,
    EXIT2_DR         = 4'h7,
    UPDATE_DR        = 4'h8,
    SELECT_IR        = 4'h9,
    CAPTURE_IR       = 4'ha,
    SHIFT_IR         = 4'hb,
    EXIT1_IR         = 4'hc,
    PAUSE_IR         = 4'hd,
    EXIT2_IR         = 4'he,
    UPDATE_IR        = 4'hf
  } tap_state_t;

  // Data register chosen by the active instruction
  typedef enum logic [2:0] {
    SEL_BYPASS   = 3'h0,
    SEL_BOUNDARY = 3'h1,
    SEL_IDENTITY = 3'h2,
    SEL_USER     = 3'h3,
    SEL_CONFIG   = 3'h4
  } dr_sel_t;

  // Instruction register
  localparam int IR_LEN = 10;
  localparam logic [IR_LEN-1:0] OP_EXTEST   = 10'h000;
  localparam logic [IR_LEN-1:0] OP_SAMPLE   = 10'h005;
  localparam logic [IR_LEN-1:0] OP_IDENTITY = 10'h006;
  localparam logic [IR_LEN-1:0] OP_USER     = 10'h007;
  localparam logic [IR_LEN-1:0] OP_CONFIG   = 10'h002;
  localparam logic [IR_LEN-1:0] OP_BYPASS   = 10'h3ff;
  localparam logic [IR_LEN-1:0] IR_CAPTURE  = 10'h001;

  // Signature registers
  localparam int SIG_LEN      = 32;
  localparam int USER_BITS    = 7;
  localparam int FIXED_BITS   = 25;
  // Identity fields; values arbitrary
  localparam logic [3:0]  ID_VERSION = 4'h5;
  localparam logic [15:0] ID_PART    = 16'h0abc;
  localparam logic [10:0] ID_MAKER   = 11'h123;
  // Fixed part of user signature; value arbitrary
  localparam logic [FIXED_BITS-1:0] USER_FIXED = 25'h0000000;

  // Boundary-scan chain length, smallest variant
  localparam int BSR_LEN_DEFAULT = 690;

  // Link clock: least period 100 ns at a 100 ns system clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCK_MIN_NS    = 100;
  localparam int TCK_MIN_CYC   = (TCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Level a floating test input reads at, via weak pull-up
  localparam logic PULLUP_LEVEL = 1'b1;

endpackage

// ### rtl/tap_sequencer.sv
// Sixteen-state test access controller
`timescale 1ns/1ps
module tap_sequencer (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      step_i,
  input  wire logic                      tms_i,
  output scan_port_pkg::tap_state_t      state_o
);

  scan_port_pkg::tap_state_t state;
  scan_port_pkg::tap_state_t next_state;

  // Standard transitions, taken only on a test-clock rise
  always_comb begin
    next_state = state;
    if (step_i) begin
      unique case (state)
        scan_port_pkg::TEST_LOGIC_RESET: next_state = tms_i ? scan_port_pkg::TEST_LOGIC_RESET
                                                            : scan_port_pkg::RUN_TEST_IDLE;
        scan_port_pkg::RUN_TEST_IDLE:    next_state = tms_i ? scan_port_pkg::SELECT_DR
                                                            : scan_port_pkg::RUN_TEST_IDLE;
        scan_port_pkg::SELECT_DR:        next_state = tms_i ? scan_port_pkg::SELECT_IR
                                                            : scan_port_pkg::CAPTURE_DR;
        scan_port_pkg::CAPTURE_DR:       next_state = tms_i ? scan_port_pkg::EXIT1_DR
                                                            : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::SHIFT_DR:         next_state = tms_i ? scan_port_pkg::EXIT1_DR
                                                            : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::EXIT1_DR:         next_state = tms_i ? scan_port_pkg::UPDATE_DR
                                                            : scan_port_pkg::PAUSE_DR;
        scan_port_pkg::PAUSE_DR:         next_state = tms_i ? scan_port_pkg::EXIT2_DR
                                                            : scan_port_pkg::PAUSE_DR;
        scan_port_pkg::EXIT2_DR:         next_state = tms_i ? scan_port_pkg::UPDATE_DR
                                                            : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::UPDATE_DR:        next_state = tms_i ? scan_port_pkg::SELECT_DR
                                                            : scan_port_pkg::RUN_TEST_IDLE;
        scan_port_pkg::SELECT_IR:        next_state = tms_i ? scan_port_pkg::TEST_LOGIC_RESET
                                                            : scan_port_pkg::CAPTURE_IR;
        scan_port_pkg::CAPTURE_IR:       next_state = tms_i ? scan_port_pkg::EXIT1_IR
                                                            : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::SHIFT_IR:         next_state = tms_i ? scan_port_pkg::EXIT1_IR
                                                            : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::EXIT1_IR:         next_state = tms_i ? scan_port_pkg::UPDATE_IR
                                                            : scan_port_pkg::PAUSE_IR;
        scan_port_pkg::PAUSE_IR:         next_state = tms_i ? scan_port_pkg::EXIT2_IR
                                                            : scan_port_pkg::PAUSE_IR;
        scan_port_pkg::EXIT2_IR:         next_state = tms_i ? scan_port_pkg::UPDATE_IR
                                                            : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::UPDATE_IR:        next_state = tms_i ? scan_port_pkg::SELECT_DR
                                                            : scan_port_pkg::RUN_TEST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= scan_port_pkg::TEST_LOGIC_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign state_o = state;

endmodule

// ### rtl/boundary_scan_test_port.sv
// Boundary-scan test port: sampled test clock, registers, pin cells
// Overview of operation
// - No boundary-scan tests while configuration runs
// - Instruction register is ten bits long
// - Sample captures pins; preload stages output pattern
// - External test drives pattern, captures input pins
// - Bypass puts one-bit stage between data pins
// - User-code instruction shifts out user signature
// - User signature: 7 configured, 25 fixed bits
// - Identity instruction shifts out 32-bit identity
// - Identity: version, part, maker, then one
// - Boundary chain length is a variant parameter
// - Configuration instructions load device through port
// - Undriven test inputs read high via pull-up
`timescale 1ns/1ps
module boundary_scan_test_port #(
  parameter int BSR_LEN = scan_port_pkg::BSR_LEN_DEFAULT
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 resetn_i,
  input  wire logic                                 tck_i,
  input  wire logic                                 tms_i,
  input  wire logic                                 tdi_i,
  output logic                                      tdo_o,
  output logic                                      tdo_oe_o,
  input  wire logic                                 config_busy_i,
  input  wire logic [scan_port_pkg::USER_BITS-1:0]  user_bits_i,
  input  wire logic [BSR_LEN-1:0]                   pin_in_i,
  input  wire logic [BSR_LEN-1:0]                   core_out_i,
  output logic      [BSR_LEN-1:0]                   pin_out_o,
  output logic      [BSR_LEN-1:0]                   core_in_o,
  output logic                                      config_bit_o,
  output logic                                      config_bit_valid_o,
  output logic      [scan_port_pkg::IR_LEN-1:0]     active_instruction_o
);

  localparam int IRW = scan_port_pkg::IR_LEN;
  localparam int SW  = scan_port_pkg::SIG_LEN;

  // Pick the data register for an instruction; bars pin tests while busy
  function automatic scan_port_pkg::dr_sel_t dr_select(input logic [IRW-1:0] op, input logic busy);
    dr_select = scan_port_pkg::SEL_BYPASS;                   // Unknown codes fall to bypass
    if ((op == scan_port_pkg::OP_EXTEST || op == scan_port_pkg::OP_SAMPLE) && !busy) begin
      dr_select = scan_port_pkg::SEL_BOUNDARY;
    end else if (op == scan_port_pkg::OP_IDENTITY) begin
      dr_select = scan_port_pkg::SEL_IDENTITY;
    end else if (op == scan_port_pkg::OP_USER) begin
      dr_select = scan_port_pkg::SEL_USER;
    end else if (op == scan_port_pkg::OP_CONFIG) begin
      dr_select = scan_port_pkg::SEL_CONFIG;
    end
  endfunction

  // Pin synchronisers; test inputs reset to the pulled-up level so a bare port idles, pin stages reset low
  logic [2:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic [BSR_LEN-1:0] pin_meta;
  logic [BSR_LEN-1:0] pin_sync;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_sync <= {3{scan_port_pkg::PULLUP_LEVEL}};
      tms_sync <= {2{scan_port_pkg::PULLUP_LEVEL}};
      tdi_sync <= {2{scan_port_pkg::PULLUP_LEVEL}};
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      tck_sync <= {tck_sync[1:0], tck_i};
      tms_sync <= {tms_sync[0], tms_i};
      tdi_sync <= {tdi_sync[0], tdi_i};
      pin_meta <= pin_in_i;
      pin_sync <= pin_meta;
    end
  end

  // Edges seen from the second and third stages only
  logic tck_rise;
  logic tck_fall;
  assign tck_rise = tck_sync[1] & ~tck_sync[2];
  assign tck_fall = ~tck_sync[1] & tck_sync[2];

  scan_port_pkg::tap_state_t state;

  // Controller steps with the sampled mode-select on each rise
  tap_sequencer u_seq (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .step_i   (tck_rise),
    .tms_i    (tms_sync[1]),
    .state_o  (state)
  );

  // Scan state
  logic [IRW-1:0]     ir_shift;
  logic [IRW-1:0]     ir_active;
  logic [SW-1:0]      sig_shift;
  logic               bypass_bit;
  logic               cfg_bit;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_update;
  logic               cfg_pulse;

  logic [IRW-1:0]     next_ir_shift;
  logic [IRW-1:0]     next_ir_active;
  logic [SW-1:0]      next_sig_shift;
  logic               next_bypass_bit;
  logic               next_cfg_bit;
  logic [BSR_LEN-1:0] next_bsr_shift;
  logic [BSR_LEN-1:0] next_bsr_update;
  logic               next_cfg_pulse;

  scan_port_pkg::dr_sel_t sel;
  assign sel = dr_select(ir_active, config_busy_i);

  // Capture, shift and update, all on a sampled test-clock rise
  always_comb begin
    next_ir_shift   = ir_shift;
    next_ir_active  = ir_active;
    next_sig_shift  = sig_shift;
    next_bypass_bit = bypass_bit;
    next_cfg_bit    = cfg_bit;
    next_bsr_shift  = bsr_shift;
    next_bsr_update = bsr_update;
    next_cfg_pulse  = 1'b0;
    if (tck_rise) begin
      unique case (state)
        scan_port_pkg::TEST_LOGIC_RESET: begin
          next_ir_active = scan_port_pkg::OP_IDENTITY;        // Identity selected after reset
        end
        scan_port_pkg::CAPTURE_IR: begin
          next_ir_shift = scan_port_pkg::IR_CAPTURE;
        end
        scan_port_pkg::SHIFT_IR: begin
          next_ir_shift = {tdi_sync[1], ir_shift[IRW-1:1]};
        end
        scan_port_pkg::UPDATE_IR: begin
          next_ir_active = ir_shift;
        end
        scan_port_pkg::CAPTURE_DR: begin
          next_bypass_bit = 1'b0;
          if (sel == scan_port_pkg::SEL_IDENTITY) begin
            next_sig_shift = {scan_port_pkg::ID_VERSION, scan_port_pkg::ID_PART,
                              scan_port_pkg::ID_MAKER, 1'b1};
          end else if (sel == scan_port_pkg::SEL_USER) begin
            next_sig_shift = {scan_port_pkg::USER_FIXED, user_bits_i};
          end
          if (sel == scan_port_pkg::SEL_BOUNDARY) begin
            next_bsr_shift = pin_sync;
          end
        end
        scan_port_pkg::SHIFT_DR: begin
          unique case (sel)
            scan_port_pkg::SEL_BYPASS: begin
              next_bypass_bit = tdi_sync[1];
            end
            scan_port_pkg::SEL_BOUNDARY: begin
              next_bsr_shift = {tdi_sync[1], bsr_shift[BSR_LEN-1:1]};
            end
            scan_port_pkg::SEL_IDENTITY,
            scan_port_pkg::SEL_USER: begin
              next_sig_shift = {tdi_sync[1], sig_shift[SW-1:1]};
            end
            scan_port_pkg::SEL_CONFIG: begin
              next_cfg_bit   = tdi_sync[1];
              next_cfg_pulse = 1'b1;
            end
          endcase
        end
        scan_port_pkg::UPDATE_DR: begin
          if (sel == scan_port_pkg::SEL_BOUNDARY) begin
            next_bsr_update = bsr_shift;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Scan registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_shift   <= scan_port_pkg::IR_CAPTURE;
      ir_active  <= scan_port_pkg::OP_IDENTITY;
      sig_shift  <= '0;
      bypass_bit <= 1'b0;
      cfg_bit    <= 1'b0;
      bsr_shift  <= '0;
      bsr_update <= '0;
      cfg_pulse  <= 1'b0;
    end else begin
      ir_shift   <= next_ir_shift;
      ir_active  <= next_ir_active;
      sig_shift  <= next_sig_shift;
      bypass_bit <= next_bypass_bit;
      cfg_bit    <= next_cfg_bit;
      bsr_shift  <= next_bsr_shift;
      bsr_update <= next_bsr_update;
      cfg_pulse  <= next_cfg_pulse;
    end
  end

  // Serial output and pin cells
  logic               next_tdo;
  logic               next_tdo_oe;
  logic [BSR_LEN-1:0] next_pin_out;
  logic               extest_on;

  // External test needs configuration idle; sample leaves pins alone
  assign extest_on = (ir_active == scan_port_pkg::OP_EXTEST) && !config_busy_i;

  always_comb begin
    next_tdo    = tdo_o;
    next_tdo_oe = tdo_oe_o;
    if (tck_fall) begin
      next_tdo_oe = (state == scan_port_pkg::SHIFT_IR) || (state == scan_port_pkg::SHIFT_DR);
      if (state == scan_port_pkg::SHIFT_IR) begin
        next_tdo = ir_shift[0];
      end else begin
        unique case (sel)
          scan_port_pkg::SEL_BOUNDARY: next_tdo = bsr_shift[0];
          scan_port_pkg::SEL_IDENTITY,
          scan_port_pkg::SEL_USER:     next_tdo = sig_shift[0];
          scan_port_pkg::SEL_CONFIG:   next_tdo = cfg_bit;
          scan_port_pkg::SEL_BYPASS:   next_tdo = bypass_bit;
        endcase
      end
    end
    next_pin_out = extest_on ? bsr_update : core_out_i;
  end

  // Output registers; core input path always follows the synchronised pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo_o                <= 1'b0;
      tdo_oe_o             <= 1'b0;
      pin_out_o            <= '0;
      core_in_o            <= '0;
      config_bit_o         <= 1'b0;
      config_bit_valid_o   <= 1'b0;
      active_instruction_o <= scan_port_pkg::OP_IDENTITY;
    end else begin
      tdo_o                <= next_tdo;
      tdo_oe_o             <= next_tdo_oe;
      pin_out_o            <= next_pin_out;
      core_in_o            <= pin_sync;
      config_bit_o         <= cfg_bit;
      config_bit_valid_o   <= cfg_pulse;
      active_instruction_o <= ir_active;
    end
  end

endmodule

// ### verification/scan_port_asserts.sv
// Concurrent checks on the boundary-scan test port pins
`timescale 1ns/1ps
module scan_port_asserts #(
  parameter int BSR_LEN = 690
) (
  input wire logic                                clk_i,
  input wire logic                                resetn_i,
  input wire logic                                tck_i,
  input wire logic                                tms_i,
  input wire logic                                tdi_i,
  input wire logic                                tdo_o,
  input wire logic                                tdo_oe_o,
  input wire logic                                config_busy_i,
  input wire logic [scan_port_pkg::USER_BITS-1:0] user_bits_i,
  input wire logic [BSR_LEN-1:0]                  pin_in_i,
  input wire logic [BSR_LEN-1:0]                  core_out_i,
  input wire logic [BSR_LEN-1:0]                  pin_out_o,
  input wire logic [BSR_LEN-1:0]                  core_in_o,
  input wire logic                                config_bit_o,
  input wire logic                                config_bit_valid_o,
  input wire logic [scan_port_pkg::IR_LEN-1:0]    active_instruction_o
);
  logic       tck_q;
  logic [7:0] fall_hist;
  logic [7:0] rise_hist;
  logic [1:0] since_rst;
  logic [7:0] next_fall;
  logic [7:0] next_rise;
  logic [1:0] next_since;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Pin-level test clock edge history; wide window absorbs the sync delay
  always_comb begin
    next_fall = {fall_hist[6:0], tck_q & ~tck_i};
    next_rise = {rise_hist[6:0], ~tck_q & tck_i};
    next_since = (since_rst == 2'h3) ? since_rst : since_rst + 2'h1;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_q <= 1'b1;
      fall_hist <= 8'h00;
      rise_hist <= 8'h00;
      since_rst <= 2'h0;
    end else begin
      tck_q <= tck_i;
      fall_hist <= next_fall;
      rise_hist <= next_rise;
      since_rst <= next_since;
    end
  end

  sequence s_tck_rise;
    !tck_i ##1 tck_i;
  endsequence
  sequence s_pulse;
    config_bit_valid_o ##1 !config_bit_valid_o;
  endsequence

  a_tdo_on_fall: assert property ($changed(tdo_o) |-> |fall_hist[5:0])
    else $error("serial output moved without a test clock fall");
  a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> |fall_hist[5:0])
    else $error("output enable moved without a test clock fall");
  a_ir_on_rise: assert property ($changed(active_instruction_o) |-> |rise_hist)
    else $error("instruction changed without a test clock rise");
  a_reset_identity: assert property ($rose(resetn_i) |-> active_instruction_o == scan_port_pkg::OP_IDENTITY)
    else $error("identity instruction not active after reset");
  a_core_in_delay: assert property (since_rst == 2'h3 |-> core_in_o == $past(pin_in_i, 3))
    else $error("core input path not three clocks behind the pins");
  a_busy_pins_core: assert property (config_busy_i |=> pin_out_o == $past(core_out_i))
    else $error("pins driven from the chain while configuring");
  a_cfg_one_pulse: assert property (config_bit_valid_o |-> s_pulse)
    else $error("configuration strobe longer than one clock");
  a_cfg_needs_op: assert property (config_bit_valid_o |-> active_instruction_o == scan_port_pkg::OP_CONFIG)
    else $error("configuration strobe under another instruction");
  a_cfg_after_rise: assert property (config_bit_valid_o |-> |rise_hist)
    else $error("configuration strobe without a test clock rise");
  c_cfg_bit: cover property (s_tck_rise ##[1:8] config_bit_valid_o);
endmodule

bind boundary_scan_test_port scan_port_asserts #(.BSR_LEN(BSR_LEN)) u_asserts (
  .clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .config_busy_i(config_busy_i), .user_bits_i(user_bits_i),
  .pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_out_o(pin_out_o), .core_in_o(core_in_o),
  .config_bit_o(config_bit_o), .config_bit_valid_o(config_bit_valid_o),
  .active_instruction_o(active_instruction_o)
);

// ### verification/jtag_controller_model.sv
// Behavioural test controller driving the scan port pins
`timescale 1ns/1ps
module jtag_controller_model #(
  parameter int MAXW = 690
) (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  // Idle lines rest at the pull-up level, test clock parked low
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One 800 ns test clock; output sampled just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_i);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    tdo = tdo_oe_i ? tdo_i : 1'b1; // Released output floats to the board pull-up
    @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask

  // Five high mode steps reach reset, then park in idle
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  // Idle to idle scan of len bits, least significant first
  task automatic scan(input bit ir, input int len, input logic [MAXW-1:0] din, output logic [MAXW-1:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir)
      step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_top;
  localparam int W = 690;
  localparam logic [9:0] BYP_OPS [2] = '{scan_port_pkg::OP_BYPASS, 10'h155};
  logic                                clk_i;
  logic                                resetn_i;
  logic                                tck, tms, tdi, tdo, tdo_oe;
  logic                                config_busy;
  logic [scan_port_pkg::USER_BITS-1:0] user_bits;
  logic [W-1:0]                        pin_in, core_out, pin_out, core_in, got, pat;
  logic                                cfg_bit, cfg_valid, cfg_last;
  logic [scan_port_pkg::IR_LEN-1:0]    active_ir;
  logic [W-1:0]                        exp_q [$];
  int                                  num_errors, comparisons, cycles, cfg_count, base, seed;
  event                                scan_ev;

  boundary_scan_test_port #(.BSR_LEN(W)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .config_busy_i(config_busy), .user_bits_i(user_bits), .pin_in_i(pin_in),
    .core_out_i(core_out), .pin_out_o(pin_out), .core_in_o(core_in), .config_bit_o(cfg_bit),
    .config_bit_valid_o(cfg_valid), .active_instruction_o(active_ir));
  jtag_controller_model #(.MAXW(W)) u_ctl (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [W-1:0] rnd();
    logic [W-1:0] v;
    for (int i = 0; i < W; i += 32)
      v = {v[W-33:0], 32'($random(seed))};
    return v;
  endfunction

  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Note the expected shift-out first, then run the scan
  task automatic drive_scan(input bit ir, input int len, input logic [W-1:0] din, input logic [W-1:0] exp);
    exp_q.push_back(exp);
    u_ctl.scan(ir, len, din, got);
    // Last rise is seen through the synchroniser; let registered outputs settle
    repeat (2) @(posedge clk_i);
    -> scan_ev;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watcher pairs each finished scan with the oldest note
  always @(scan_ev) begin
    check("scan data", got, exp_q.pop_front());
  end

  // Count configuration strobes and keep the last bit
  always @(posedge clk_i) begin
    if (cfg_valid === 1'b1) begin
      cfg_count <= cfg_count + 1;
      cfg_last <= cfg_bit;
    end
  end

  // Hang guard, well above the roughly 13k clocks the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    seed = 70447;
    resetn_i = 1'b0;
    config_busy = 1'b0;
    user_bits = '0;
    pin_in = '0;
    core_out = '0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    cfg_count = 0;
    cfg_last = 1'b0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    user_bits <= 7'($random(seed));
    core_out <= rnd();
    pin_in <= rnd();
    repeat (4) @(posedge clk_i);
    check("reset instruction", W'(active_ir), W'(scan_port_pkg::OP_IDENTITY));
    u_ctl.tap_reset();
    drive_scan(1'b0, 32, rnd(), W'({scan_port_pkg::ID_VERSION, scan_port_pkg::ID_PART,
      scan_port_pkg::ID_MAKER, 1'b1}));
    check("enable at idle", W'(tdo_oe), W'(1'b0));
    drive_scan(1'b1, 10, W'(scan_port_pkg::OP_USER), W'(scan_port_pkg::IR_CAPTURE));
    check("user instruction", W'(active_ir), W'(scan_port_pkg::OP_USER));
    drive_scan(1'b0, 32, rnd(), W'({scan_port_pkg::USER_FIXED, user_bits}));
    // Named and unknown opcodes both fall to the one-bit stage
    for (int k = 0; k < 2; k++) begin
      drive_scan(1'b1, 10, W'(BYP_OPS[k]), W'(scan_port_pkg::IR_CAPTURE));
      pat = rnd();
      drive_scan(1'b0, 16, pat, W'({pat[14:0], 1'b0}));
    end
    drive_scan(1'b1, 10, W'(scan_port_pkg::OP_SAMPLE), W'(scan_port_pkg::IR_CAPTURE));
    pat = rnd();
    drive_scan(1'b0, W, pat, pin_in);
    check("pins in sample", pin_out, core_out);
    drive_scan(1'b1, 10, W'(scan_port_pkg::OP_EXTEST), W'(scan_port_pkg::IR_CAPTURE));
    check("preloaded pins", pin_out, pat);
    pin_in <= rnd();
    pat = rnd();
    repeat (4) @(posedge clk_i);
    check("core input", core_in, pin_in);
    drive_scan(1'b0, W, pat, pin_in);
    check("pins in extest", pin_out, pat);
    // Boundary test requested while configuring: bypass, core keeps pins
    config_busy <= 1'b1;
    pat = rnd();
    drive_scan(1'b0, 16, pat, W'({pat[14:0], 1'b0}));
    check("pins while busy", pin_out, core_out);
    config_busy <= 1'b0;
    drive_scan(1'b1, 10, W'(scan_port_pkg::OP_CONFIG), W'(scan_port_pkg::IR_CAPTURE));
    base = cfg_count;
    pat = rnd();
    u_ctl.scan(1'b0, 16, pat, got);
    repeat (4) @(posedge clk_i);
    check("config strobes", W'(cfg_count - base), W'(16));
    check("config last bit", W'(cfg_last), W'(pat[15]));
    u_ctl.tap_reset();
    check("instruction after reset", W'(active_ir), W'(scan_port_pkg::OP_IDENTITY));
    close_out();
  end
endmodule
